// ### hw/ifs_sequencer.sv
// ignition fault/status sequencer top: fault waits, retry delays, lockout, status led
// assumes all inputs synchronous to clk; trial outcomes arrive as one-cycle pulses
`default_nettype none
module ifs_sequencer
  import ifs_pkg::*;
#(
  parameter longint unsigned TICK_CYCLES = TICK_CYC // shorten in simulation
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic heat_demand, // thermostat call for heat
  input wire logic flame_sensed, // flame present
  input wire logic leak_fault, // flame sense leakage to ground
  input wire logic low_supply, // low secondary supply
  input wire logic selfcheck_err, // internal self-check failed, pulse
  input wire logic trial_expecting, // trial or run: flame is expected now
  input wire logic trial_failed, // pulse: no pilot proven in trial
  input wire logic flame_lost_run, // pulse: flame failed during run
  output logic [1:0] led_level, // 0 dark, 1 dim, 3 bright
  output logic hold_off, // valves and spark held off
  output logic soft_lockout // in soft lockout
);
  typedef enum logic [6:0] {
    ST_NORM = 7'h01, ST_FWAIT = 7'h02, ST_FDELAY = 7'h04, ST_RETRY = 7'h08,
    ST_STRAY = 7'h10, ST_STRAYW = 7'h20, ST_LOCK = 7'h40
  } ifs_st_t;
  typedef struct packed {
    ifs_st_t st;
    logic [31:0] pre; // tick prescaler
    logic tick;
    logic [15:0] cnt; // timer in ticks
    logic [2:0] retries; // failed trials this demand
    logic [2:0] losses; // run flame losses this demand
    logic [3:0] cx; // code shown
    logic [3:0] cy;
    logic on_lock; // lockout from self check
    logic hold_reg;
    logic lock_reg;
    logic [1:0] led_reg;
  } ifs_seq_t;
  ifs_seq_t s, sn;
  ifs_disp_if d();

  // main state step
  always_comb begin
    sn = s;
    sn.tick = 1'b0;
    sn.pre = s.pre + 32'h1;
    if (s.pre >= 32'(TICK_CYCLES - 64'd1)) begin
      sn.pre = 32'h0;
      sn.tick = 1'b1;
    end
    if (s.tick && s.cnt != 16'h0) sn.cnt = s.cnt - 16'h0001;
    // R13: counters clear when demand ends
    if (!heat_demand) begin
      sn.retries = 3'h0;
      sn.losses = 3'h0;
    end
    case (s.st)
      ST_NORM: begin
        if (heat_demand) begin
          sn.cx = 4'h0;
          sn.cy = 4'h0;
        end
        if (leak_fault || low_supply) begin
          // R1: leakage wait code 7
          // R2: low supply code 8
          sn.st = ST_FWAIT;
          sn.cx = leak_fault ? 4'h7 : 4'h8;
          sn.cy = 4'h0;
        end else if (flame_sensed && !trial_expecting) begin
          sn.st = ST_STRAY;
          sn.cnt = STRAY_TK;
          sn.cx = 4'h4;
          sn.cy = 4'h0;
        end else if (heat_demand && trial_failed) begin
          sn.st = ST_RETRY;
          sn.cnt = RETRY_TK;
          sn.retries = s.retries + 3'h1;
          // R3: every third retry escalates
          if (s.retries + 3'h1 == RETRY_ESC) begin
            sn.retries = 3'h0;
            sn.cx = 4'h6;
            sn.cy = 4'h2;
          end else begin
            // R12: no pilot, code 2 five minutes
            sn.cx = 4'h2;
            sn.cy = 4'h0;
          end
        end else if (heat_demand && flame_lost_run) begin
          sn.losses = s.losses + 3'h1;
          sn.cx = 4'h3;
          // R4: sixth loss escalates to delay
          if (s.losses + 3'h1 == LOSS_ESC) begin
            sn.losses = 3'h0;
            sn.st = ST_RETRY;
            sn.cnt = RETRY_TK;
            sn.cx = 4'h6;
            sn.cy = 4'h3;
          end
        end
      end
      // held while fault present
      ST_FWAIT: begin
        if (!leak_fault && !low_supply) begin
          sn.st = ST_FDELAY;
          sn.cnt = WAIT_TK;
        end
      end
      // R1: one minute after clearing
      ST_FDELAY: begin
        if (leak_fault || low_supply) sn.st = ST_FWAIT;
        else if (s.cnt == 16'h0) sn.st = ST_NORM;
      end
      // R12: timed retry delay, then new trial
      ST_RETRY: begin
        if (s.cnt == 16'h0 || !heat_demand) sn.st = ST_NORM;
      end
      ST_STRAY: begin
        // R11: cleared in time, back to normal
        if (!flame_sensed) begin
          sn.st = ST_NORM;
          sn.cx = 4'h0;
        end else if (s.cnt == 16'h0) begin
          // R5: over ten seconds, code 6+4
          sn.st = ST_STRAYW;
          sn.cx = 4'h6;
          sn.cy = 4'h4;
        end
      end
      // R5: wait for flame gone, then lockout
      ST_STRAYW: begin
        if (!flame_sensed) begin
          sn.st = ST_LOCK;
          sn.cnt = LOCK_TK;
        end
      end
      // R6: one hour auto reset
      ST_LOCK: begin
        if (s.cnt == 16'h0) begin
          sn.st = ST_NORM;
          sn.on_lock = 1'b0;
          sn.cx = 4'h0;
          sn.cy = 4'h0;
          sn.retries = 3'h0;
          sn.losses = 3'h0;
        end
      end
      default: sn.st = ST_NORM;
    endcase
    // R7: self-check error forces lockout
    if (selfcheck_err && s.st != ST_LOCK) begin
      sn.st = ST_LOCK;
      sn.cnt = LOCK_TK;
      sn.on_lock = 1'b1;
    end
    sn.hold_reg = (sn.st != ST_NORM);
    sn.lock_reg = (sn.st == ST_LOCK);
    sn.led_reg = d.led;
  end

  // display selection from current state
  always_comb begin
    d.tick = s.tick;
    d.first = s.cx;
    d.second = s.cy;
    if (s.on_lock) d.mode = IFS_D_ON;
    else if (s.cx != 4'h0) d.mode = IFS_D_CODE;
    else if (heat_demand) d.mode = IFS_D_BEAT;
    else d.mode = IFS_D_OFF;
  end

  ifs_led_gen u_led (
    .clk(clk),
    .reset_n(reset_n),
    .d(d.gen)
  );

  // state register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '{st: ST_NORM, pre: 32'h0, tick: 1'b0, cnt: 16'h0, retries: 3'h0, losses: 3'h0,
             cx: 4'h0, cy: 4'h0, on_lock: 1'b0, hold_reg: 1'b0, lock_reg: 1'b0,
             led_reg: LED_DARK};
    end else begin
      s <= sn;
    end
  end
  assign led_level = s.led_reg;
  assign hold_off = s.hold_reg;
  assign soft_lockout = s.lock_reg;
endmodule : ifs_sequencer
`default_nettype wire

// ### hw/ifs_pkg.sv
// constants and types, including the display selection type, for the ignition fault/status sequencer
// assumes a single 200 MHz clock and synchronous inputs
// Function
// R1: leakage fault: wait, code 7, one-minute delay
// R2: low supply: wait, code 8, one-minute delay
// R3: third retry per demand: code 6+2, delay
// R4: sixth flame loss per demand: 6+3, delay
// R5: stray flame over 10 s: 6+4, lockout
// R6: soft lockout auto resets after one hour
// R7: self-check error: soft lockout, LED on
// R8: heartbeat: half second bright, half dim
// R9: single code: flashes at 2 Hz, 2 s dark
// R10: two-part code: X, 2 s, Y, 3 s dark
// R11: stray flame gone within 10 s: resume
// R12: no pilot proven: code 2, five-minute wait
// R13: escalation counters clear when demand ends
`default_nettype none
package ifs_pkg;
  // timing base
  localparam longint unsigned CLK_HZ = 64'd200000000;
  localparam longint unsigned TICK_MS = 64'd250;
  localparam longint unsigned TICK_CYC = CLK_HZ / 64'd1000 * TICK_MS;
  // times in seconds, converted to quarter-second ticks
  localparam int unsigned WAIT_S = 60;
  localparam int unsigned RETRY_S = 300;
  localparam int unsigned STRAY_S = 10;
  localparam int unsigned LOCK_S = 3600;
  localparam int unsigned TPS = 4;
  localparam logic [15:0] WAIT_TK = 16'(WAIT_S * TPS);
  localparam logic [15:0] RETRY_TK = 16'(RETRY_S * TPS);
  localparam logic [15:0] STRAY_TK = 16'(STRAY_S * TPS);
  localparam logic [15:0] LOCK_TK = 16'(LOCK_S * TPS);
  // flash pattern figures in ticks, then escalation counts
  localparam logic [4:0] HALF_TK = 5'h02;
  localparam logic [4:0] GAP1_TK = 5'h08;
  localparam logic [4:0] GAP2_TK = 5'h0c;
  localparam logic [2:0] RETRY_ESC = 3'h3;
  localparam logic [2:0] LOSS_ESC = 3'h6;
  // display selections
  typedef enum logic [2:0] {
    IFS_D_OFF = 3'h0,
    IFS_D_ON = 3'h1,
    IFS_D_BEAT = 3'h2,
    IFS_D_CODE = 3'h3
  } ifs_disp_t;
  // led levels: 2'h0 dark, 2'h1 dim, 2'h3 bright
  localparam logic [1:0] LED_DARK = 2'h0;
  localparam logic [1:0] LED_DIM = 2'h1;
  localparam logic [1:0] LED_BRIGHT = 2'h3;
endpackage : ifs_pkg
`default_nettype wire

// ### hw/ifs_disp_if.sv
// carrier between sequencer and led pattern generator
// one clock domain, no handshake
`default_nettype none
interface ifs_disp_if;
  import ifs_pkg::*;
  ifs_disp_t mode; // what to show
  logic [3:0] first; // x flashes
  logic [3:0] second; // y flashes, zero for single code
  logic tick; // quarter-second strobe
  logic [1:0] led; // resulting level
  modport ctl (output mode, output first, output second, output tick, input led);
  modport gen (input mode, input first, input second, input tick, output led);
endinterface : ifs_disp_if
`default_nettype wire

// ### hw/ifs_led_gen.sv
// led flash-pattern generator: heartbeat, single and two-part codes
// assumes a quarter-second tick strobe from the sequencer
`default_nettype none
module ifs_led_gen
  import ifs_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  ifs_disp_if.gen d
);
  typedef enum logic [3:0] {
    PG_FL1 = 4'h1, PG_GAP1 = 4'h2, PG_FL2 = 4'h4, PG_GAP2 = 4'h8
  } ifs_pg_t;
  typedef struct packed {
    ifs_pg_t ph; // pattern phase
    logic [4:0] tk; // ticks inside step
    logic [3:0] n; // flashes done
    logic [1:0] led_reg;
  } ifs_lg_t;
  ifs_lg_t s, sn;
  // flash index: lit for the first quarter second of each 2 Hz period
  function automatic logic flash_on(input logic [4:0] t);
    flash_on = (t == 5'h00);
  endfunction : flash_on

  // pattern stepping, one step per tick
  always_comb begin
    sn = s;
    if (d.mode != IFS_D_CODE) begin
      sn.ph = PG_FL1;
      sn.n = 4'h0;
    end
    if (d.tick) begin
      sn.tk = s.tk + 5'h01;
      case (d.mode)
        // R8: heartbeat halves
        IFS_D_BEAT: begin
          if (s.tk == HALF_TK - 5'h01) sn.led_reg = (s.led_reg == LED_BRIGHT) ? LED_DIM : LED_BRIGHT;
          if (s.tk == HALF_TK - 5'h01) sn.tk = 5'h00;
        end
        // R7: steady on
        IFS_D_ON: begin
          sn.led_reg = LED_BRIGHT;
          sn.tk = 5'h00;
        end
        IFS_D_CODE: begin
          case (s.ph)
            // R9, R10: x and y flashes at 2 Hz
            PG_FL1, PG_FL2: begin
              sn.led_reg = flash_on(s.tk) ? LED_BRIGHT : LED_DARK;
              // one 2 Hz period is half a second; >= also recovers a stale count
              if (s.tk >= HALF_TK - 5'h01) begin
                sn.tk = 5'h00;
                sn.n = s.n + 4'h1;
                if (s.n + 4'h1 >= ((s.ph == PG_FL1) ? d.first : d.second)) begin
                  sn.n = 4'h0;
                  sn.ph = (s.ph == PG_FL1) ? PG_GAP1 : PG_GAP2;
                end
              end
            end
            // R9: two seconds dark after x
            PG_GAP1: begin
              sn.led_reg = LED_DARK;
              if (s.tk == GAP1_TK - 5'h01) begin
                sn.tk = 5'h00;
                sn.ph = (d.second == 4'h0) ? PG_FL1 : PG_FL2;
              end
            end
            // R10: three seconds dark after y
            PG_GAP2: begin
              sn.led_reg = LED_DARK;
              if (s.tk == GAP2_TK - 5'h01) begin
                sn.tk = 5'h00;
                sn.ph = PG_FL1;
              end
            end
            default: sn.ph = PG_FL1;
          endcase
        end
        default: begin
          sn.led_reg = LED_DARK;
          sn.tk = 5'h00;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '{ph: PG_FL1, tk: 5'h00, n: 4'h0, led_reg: LED_DARK};
    end else begin
      s <= sn;
    end
  end
  assign d.led = s.led_reg;
endmodule : ifs_led_gen
`default_nettype wire

// ### verification/ifs_sequencer_monitor.sv
// checker on the sequencer ports: holds, lockout entry and exit, steady led
// assumes it is bound onto ifs_sequencer, one clock domain
`default_nettype none
module ifs_sequencer_monitor
  import ifs_pkg::*;
#(
  parameter longint unsigned TICK_CYCLES = TICK_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic heat_demand,
  input wire logic flame_sensed,
  input wire logic leak_fault,
  input wire logic low_supply,
  input wire logic selfcheck_err,
  input wire logic trial_expecting,
  input wire logic trial_failed,
  input wire logic flame_lost_run,
  input wire logic [1:0] led_level,
  input wire logic hold_off,
  input wire logic soft_lockout
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic self_lk; // lockout was caused by the self-check
  // remember the cause, since the stray-flame lockout flashes instead
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      self_lk <= 1'b0;
    end else if (selfcheck_err && !soft_lockout) begin
      self_lk <= 1'b1;
    end else if (!soft_lockout) begin
      self_lk <= 1'b0;
    end
  end
  leak_hold_a: assert property (leak_fault |=> hold_off)
    else $error("hold_off low under leakage");
  low_hold_a: assert property (low_supply |=> hold_off)
    else $error("hold_off low under low supply");
  fail_hold_a: assert property (trial_failed && heat_demand && !hold_off
    && !(flame_sensed && !trial_expecting) |=> hold_off) else $error("no retry hold");
  self_lock_a: assert property (selfcheck_err |=> soft_lockout)
    else $error("self-check error without lockout");
  lock_hold_a: assert property (soft_lockout |-> hold_off)
    else $error("lockout without hold_off");
  lock_keep_a: assert property ($rose(soft_lockout) |=> soft_lockout [*8])
    else $error("lockout ended at once");
  lock_cause_a: assert property ($rose(soft_lockout)
    |-> $past(selfcheck_err) || !$past(flame_sensed)) else $error("lockout with flame");
  clean_drop_a: assert property ($fell(hold_off)
    |-> !$past(leak_fault) && !$past(low_supply)) else $error("resumed under fault");
  steady_led_a: assert property (self_lk && soft_lockout && led_level == LED_BRIGHT
    |=> led_level == LED_BRIGHT || !soft_lockout) else $error("led not steady");
endmodule : ifs_sequencer_monitor
bind ifs_sequencer ifs_sequencer_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (.clk, .reset_n,
  .heat_demand, .flame_sensed, .leak_fault, .low_supply, .selfcheck_err, .trial_expecting,
  .trial_failed, .flame_lost_run, .led_level, .hold_off, .soft_lockout);
`default_nettype wire

// ### verification/ifs_plant.sv
// far-side stand-in: thermostat call and flame sensing feeding the sequencer
// assumes the bench sets its command levels at the falling clock edge
`default_nettype none
module ifs_plant (
  input wire logic heat, // thermostat contacts closed
  input wire logic fire, // flame at the sensor
  input wire logic run, // sequence expects flame
  input wire logic fail, // trial ended unproven
  input wire logic loss, // flame dropped in run
  output logic heat_demand,
  output logic flame_sensed,
  output logic trial_expecting,
  output logic trial_failed,
  output logic flame_lost_run
);
  // no trial outside a call, so outcomes follow the call
  assign heat_demand = heat;
  assign flame_sensed = fire;
  assign trial_expecting = run && heat;
  assign trial_failed = fail && heat;
  assign flame_lost_run = loss && heat;
endmodule : ifs_plant
`default_nettype wire

// ### verification/ifs_sequencer_tb_top.sv
// self-checking bench for the ignition fault/status sequencer
// assumes a 4-cycle tick so every delay runs in at most tens of thousands of cycles
`default_nettype none
module ifs_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ifs_pkg::*;
  localparam int TC = 4; // cycles per tick
  localparam int RD = int'(RETRY_TK) * TC;
  localparam int WD = int'(WAIT_TK) * TC;
  localparam int LD = int'(LOCK_TK) * TC;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic heat = 1'b0, fire = 1'b0, run = 1'b0, fail = 1'b0, loss = 1'b0;
  logic leak = 1'b0, low = 1'b0, self_err = 1'b0;
  wire logic heat_demand, flame_sensed, trial_expecting, trial_failed, flame_lost_run;
  wire logic [1:0] led_level;
  wire logic hold_off, soft_lockout;
  int mismatches = 0, n_compared = 0;
  ifs_plant u_plant (.heat, .fire, .run, .fail, .loss, .heat_demand, .flame_sensed,
    .trial_expecting, .trial_failed, .flame_lost_run);
  ifs_sequencer #(.TICK_CYCLES(TC)) DUT (.clk, .reset_n, .heat_demand, .flame_sensed,
    .leak_fault(leak), .low_supply(low), .selfcheck_err(self_err), .trial_expecting,
    .trial_failed, .flame_lost_run, .led_level, .hold_off, .soft_lockout);
  initial forever #2.5 clk = ~clk;
  task automatic summarize();
    $display("compared %0d, mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  // tolerance only for timer spans, which move by a tick
  task automatic chk(string w, logic [31:0] e, logic [31:0] g, int tol = 0);
    n_compared++;
    if ($isunknown(g) || (tol == 0 ? g !== e : (g + tol < e || g > e + tol))) begin
      mismatches++;
      $display("unexpected %s: expected %0d, seen %0d", w, e, g);
    end
  endtask : chk
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask : pulse
  task automatic cnt(input int n, input logic [1:0] lv, output int c);
    c = 0;
    repeat (n) begin
      @(negedge clk);
      if (led_level === lv) c++;
    end
  endtask : cnt
  // bounded wait for hold_off or soft_lockout to drop
  task automatic span(input bit lk, input int lim, output int t);
    t = 0;
    while ((lk ? soft_lockout : hold_off) !== 1'b0 && t < lim) begin
      @(negedge clk);
      t++;
    end
  endtask : span
  task automatic redo();
    heat = 1'b0;
    cyc(4);
    heat = 1'b1;
    cyc(4);
  endtask : redo
  // one outcome pulse: code seen over a full period, then the delay
  task automatic round(ref logic s, input int per, input int dark);
    int t;
    pulse(s);
    cyc(2);
    chk("hold_off", 1, hold_off);
    cyc(per);
    cnt(per, LED_DARK, t);
    chk("dark cycles", dark, t);
    span(0, RD + 100, t);
    chk("retry cycles", RD, t + 2 * per + 3, 12);
  endtask : round
  task automatic t_fault(ref logic s, input int per, input int dark);
    int t;
    s = 1'b1;
    cyc(3);
    chk("hold_off", 1, hold_off);
    cyc(per);
    cnt(per, LED_DARK, t);
    chk("dark cycles", dark, t);
    s = 1'b0;
    span(0, WD + 100, t);
    chk("wait cycles", WD, t, 12);
    $display("fault test done");
  endtask : t_fault
  task automatic t_start();
    int c;
    heat = 1'b1;
    cyc(16);
    cnt(64, LED_BRIGHT, c);
    chk("bright cycles", 32, c);
    chk("hold_off", 0, hold_off);
    round(fail, 48, 40);
    round(fail, 48, 40);
    redo();
    round(fail, 48, 40);
    round(fail, 48, 40);
    round(fail, 144, 112);
    $display("retry test done");
  endtask : t_start
  task automatic t_loss();
    redo();
    run = 1'b1;
    fire = 1'b1;
    cyc(8);
    repeat (5) begin
      pulse(loss);
      cyc(6);
    end
    round(loss, 152, 116);
    run = 1'b0;
    fire = 1'b0;
    cyc(4);
    $display("loss test done");
  endtask : t_loss
  task automatic t_stray();
    int t;
    fire = 1'b1;
    cyc(60);
    fire = 1'b0;
    cyc(8);
    chk("hold_off", 0, hold_off);
    fire = 1'b1;
    cyc(360);
    cnt(160, LED_DARK, t);
    chk("dark cycles", 120, t);
    chk("lockout", 0, soft_lockout);
    fire = 1'b0;
    cyc(3);
    chk("lockout", 1, soft_lockout);
    cnt(160, LED_DARK, t);
    chk("dark cycles", 120, t);
    span(1, LD + 100, t);
    chk("lockout cycles", LD, t + 163, 12);
    $display("stray flame test done");
  endtask : t_stray
  task automatic t_self();
    int t;
    pulse(self_err);
    cyc(2);
    chk("lockout", 1, soft_lockout);
    cyc(8);
    cnt(32, LED_BRIGHT, t);
    chk("bright cycles", 32, t);
    reset_n = 1'b0;
    cyc(2);
    reset_n = 1'b1;
    cyc(2);
    chk("lockout", 0, soft_lockout);
    $display("self-check test done");
  endtask : t_self
  // watchdog sized a little above the longest expected run
  initial begin
    repeat (99000) @(posedge clk);
    mismatches++;
    summarize();
  end
  initial begin
    cyc(10);
    reset_n = 1'b1;
    cyc(2);
    t_start();
    t_loss();
    t_fault(leak, 88, 60);
    t_fault(low, 96, 64);
    t_stray();
    t_self();
    summarize();
  end
endmodule : ifs_sequencer_tb_top
`default_nettype wire
